// *** dac_ctrl_cfg.svh ***
// Register offsets, field positions, reset values and timing counts for the DAC control block.
// Assumes inclusion by bare name from the design file.
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_MAIN_CONTROL 6'h00
`define OFS_CHANNEL_TRIGGER_CONTROL 6'h01
`define OFS_REFERENCE_ALIGN_CONTROL 6'h02
`define OFS_EVENT_SOURCE_CONTROL 6'h03
`define OFS_BUFFER_EMPTY_FLAGS 6'h05
`define OFS_CONVERTER_STATE 6'h06
`define OFS_CHAN0_SAMPLE_LOW 6'h18
`define OFS_CHAN0_SAMPLE_HIGH 6'h19
`define OFS_CHAN1_SAMPLE_LOW 6'h1a
`define OFS_CHAN1_SAMPLE_HIGH 6'h1b

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_GLOBAL_ENABLE 0
`define BIT_LOW_POWER_SELECT 1
`define BIT_CH0_PIN_OUTPUT_ENABLE 2
`define BIT_CH1_PIN_OUTPUT_ENABLE 3
`define BIT_INTERNAL_ROUTE_ENABLE 4
`define MASK_MAIN_CONTROL 8'h1f
`define MASK_CHANNEL_TRIGGER_CONTROL 8'h63
`define MASK_REFERENCE_ALIGN_CONTROL 8'h19
`define MASK_EVENT_SOURCE_CONTROL 8'h0f
`define MASK_BUFFER_EMPTY_FLAGS 8'h03

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL 8'h00
`define RST_EMPTY_FLAGS 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CONV_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COUNT_W 8

`endif

// *** dac_ctrl_pkg.sv ***
// Types shared by the DAC control block.
// Assumes the configuration header sits in the same folder.
package dac_ctrl_pkg;

   typedef enum logic [1:0] {
      channel_usage_select_single_ch0 = 2'b00,
      channel_usage_select_solo_channel_one = 2'b01,
      channel_usage_select_dual = 2'b10,
      channel_usage_select_reserved = 2'b11
   } channel_usage_t;

   typedef enum logic [1:0] {
      internal_one_volt_ref = 2'b00,
      analog_supply_ref = 2'b01,
      external_ref_port_a = 2'b10,
      external_ref_port_b = 2'b11
   } reference_source_t;

   typedef enum logic [1:0] {
      conv_idle = 2'b00,
      conv_busy = 2'b01
   } conv_state_t;

endpackage

// *** dual_channel_dac_control.sv ***
// Register file, sample staging and conversion sequencing of a two-channel 12-bit DAC.
// Assumes a single-cycle register port on clk_in and event lines from another domain.
// What this block does
// (RQ1) In low-power mode the conversion core is powered down between conversions.
// (RQ2) Low-power conversions take twice the normal conversion time.
// (RQ3) Global enable bit gates all conversions.
// (RQ4) Channel select: 00 channel zero, 01 channel one, 10 both, 11 reserved.
// (RQ5) Channel one event trigger starts conversion only if its sample was written.
// (RQ6) Channel zero event trigger starts conversion only if its sample was updated.
// (RQ7) Reference select: 00 internal 1.00V, 01 supply, 10 port A, 11 port B.
// (RQ8) Alignment bit selects left-aligned byte layout for both channels.
// (RQ9) Event select bit 3 gives channel one event channel select plus one.
// (RQ10) Low three event select bits pick event channel zero to seven.
// (RQ11) Each channel has an empty flag, channel one bit 1, channel zero bit 0.
// (RQ12) Writing while not empty replaces the pending sample.
// (RQ13) Empty flags drive the DMA request lines directly.
// (RQ14) Right-aligned: low byte bits 7:0, high byte low nibble bits 11:8.
// (RQ15) Left-aligned: high byte bits 11:4, low byte upper nibble bits 3:0.
// (RQ16) Left-aligned 8-bit writes use only the high byte with cleared staging.
// (RQ17) Reserved control bits read as zero.
// (RQ18) Without event triggering a written sample converts automatically.
// (RQ19) Pin enables route channels; internal route suppresses channel zero pin.
// (RQ20) All transfers run on the peripheral clock.
// (RQ21) Low-byte write is staged; high-byte write commits both bytes atomically.
// (RQ22) A conversion taking the sample sets empty and clears the updated marker.
`include "dac_ctrl_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module dual_channel_dac_control (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [5:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Event system channels
   input wire logic [7:0] event_in,
   // DMA requests
   output logic [1:0] dma_req_out,
   // Conversion core
   output logic [11:0] ch0_sample_out,
   output logic [11:0] ch1_sample_out,
   output logic [1:0] core_power_out,
   output logic [1:0] ref_select_out,
   output logic [1:0] pin_enable_out,
   output logic internal_route_out
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Register view of one sample under the current alignment
   function automatic logic [7:0] sample_view(input logic [11:0] s, input logic left, input logic high);
      logic [7:0] r;
      r = 8'h00;
      if (left) begin
         r = high ? s[11:4] : {s[3:0], 4'h0}; // RQ15
      end else begin
         r = high ? {4'h0, s[11:8]} : s[7:0]; // RQ14
      end
      return r;
   endfunction

   // Merge staged low byte with the high byte into a 12-bit sample
   function automatic logic [11:0] sample_join(input logic [7:0] lo, input logic [7:0] hi, input logic left);
      logic [11:0] r;
      r = 12'h000;
      if (left) begin
         r = {hi, lo[7:4]}; // RQ15 RQ16
      end else begin
         r = {hi[3:0], lo}; // RQ14
      end
      return r;
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] main_control_q;
   logic [7:0] channel_trigger_control_q;
   logic [7:0] reference_align_control_q;
   logic [7:0] event_source_control_q;
   logic [7:0] staging_q;
   logic [11:0] sample_q [2];
   logic [11:0] out_sample_q [2];
   logic [1:0] empty_q;
   logic [1:0] updated_q;
   logic [1:0] take;
   logic [1:0] sample_wr;
   logic [7:0] ev_meta_q;
   logic [7:0] ev_sync_q;
   logic [7:0] ev_prev_q;
   logic [7:0] ev_rise;
   logic [1:0] ev_hit;
   logic [2:0] ev_ch1_sel;
   logic [1:0] chan_on;
   logic [1:0] core_power_q;
   logic [`COUNT_W-1:0] busy_cnt_q [2];
   dac_ctrl_pkg::conv_state_t conv_state_q [2];

   wire logic global_en = main_control_q[`BIT_GLOBAL_ENABLE];
   wire logic low_power = main_control_q[`BIT_LOW_POWER_SELECT];
   wire logic left_align_select = reference_align_control_q[0];
   wire dac_ctrl_pkg::channel_usage_t channel_usage_select =
      dac_ctrl_pkg::channel_usage_t'(channel_trigger_control_q[6:5]);

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Every register and sample path runs on clk_in alone
   always_ff @(posedge clk_in or negedge nrst_in) begin // RQ20
      if (!nrst_in) begin
         main_control_q <= `RST_CONTROL;
         channel_trigger_control_q <= `RST_CONTROL;
         reference_align_control_q <= `RST_CONTROL;
         event_source_control_q <= `RST_CONTROL;
      end else if (wr_in) begin
         unique case (addr_in)
            `OFS_MAIN_CONTROL: main_control_q <= wdata_in & `MASK_MAIN_CONTROL; // RQ17
            `OFS_CHANNEL_TRIGGER_CONTROL: channel_trigger_control_q <= wdata_in & `MASK_CHANNEL_TRIGGER_CONTROL; // RQ17
            `OFS_REFERENCE_ALIGN_CONTROL: reference_align_control_q <= wdata_in & `MASK_REFERENCE_ALIGN_CONTROL; // RQ17
            `OFS_EVENT_SOURCE_CONTROL: event_source_control_q <= wdata_in & `MASK_EVENT_SOURCE_CONTROL; // RQ17
            default: ;
         endcase
      end
   end

   // Shared staging byte for both channels
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         staging_q <= 8'h00;
      end else if (wr_in && (addr_in == `OFS_CHAN0_SAMPLE_LOW || addr_in == `OFS_CHAN1_SAMPLE_LOW)) begin
         staging_q <= left_align_select ? {wdata_in[7:4], 4'h0} : wdata_in; // RQ21 RQ15
      end
   end

   assign sample_wr[0] = wr_in && addr_in == `OFS_CHAN0_SAMPLE_HIGH;
   assign sample_wr[1] = wr_in && addr_in == `OFS_CHAN1_SAMPLE_HIGH;

   // ----------------------------------------
   // Event inputs
   // ----------------------------------------
   // Event lines come from another domain, so they pass two flops first
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ev_meta_q <= 8'h00;
         ev_sync_q <= 8'h00;
         ev_prev_q <= 8'h00;
      end else begin
         ev_meta_q <= event_in;
         ev_sync_q <= ev_meta_q;
         ev_prev_q <= ev_sync_q;
      end
   end

   assign ev_rise = ev_sync_q & ~ev_prev_q;
   // Channel one wraps from seven to zero when offset by one
   assign ev_ch1_sel = event_source_control_q[3] ? event_source_control_q[2:0] + 3'h1
                                                 : event_source_control_q[2:0]; // RQ9
   assign ev_hit[0] = ev_rise[event_source_control_q[2:0]]; // RQ10
   assign ev_hit[1] = ev_rise[ev_ch1_sel]; // RQ9

   assign chan_on[0] = global_en && (channel_usage_select == dac_ctrl_pkg::channel_usage_select_single_ch0 ||
                                     channel_usage_select == dac_ctrl_pkg::channel_usage_select_dual); // RQ3 RQ4
   assign chan_on[1] = global_en && (channel_usage_select == dac_ctrl_pkg::channel_usage_select_solo_channel_one ||
                                     channel_usage_select == dac_ctrl_pkg::channel_usage_select_dual); // RQ3 RQ4

   // ----------------------------------------
   // Per-channel sample and conversion
   // ----------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_chan
      // Conversion starts only when idle; a busy channel keeps its sample pending
      assign take[c] = chan_on[c] && updated_q[c] && conv_state_q[c] == dac_ctrl_pkg::conv_idle &&
                       (channel_trigger_control_q[c] ? ev_hit[c] : 1'b1); // RQ5 RQ6 RQ18

      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            sample_q[c] <= 12'h000;
         end else if (sample_wr[c]) begin
            sample_q[c] <= sample_join(staging_q, wdata_in, left_align_select); // RQ21 RQ12
         end
      end

      // Write wins over a same-cycle take so no new sample is lost
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            empty_q[c] <= 1'b0;
            updated_q[c] <= 1'b0;
         end else if (sample_wr[c]) begin
            empty_q[c] <= 1'b0; // RQ21 RQ12
            updated_q[c] <= 1'b1;
         end else if (take[c]) begin
            empty_q[c] <= 1'b1; // RQ22 RQ11
            updated_q[c] <= 1'b0;
         end
      end

      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            conv_state_q[c] <= dac_ctrl_pkg::conv_idle;
            busy_cnt_q[c] <= '0;
            out_sample_q[c] <= 12'h000;
         end else begin
            unique case (conv_state_q[c])
               dac_ctrl_pkg::conv_idle: begin
                  if (take[c]) begin
                     out_sample_q[c] <= sample_q[c];
                     busy_cnt_q[c] <= low_power ? `COUNT_W'(2 * `CONV_CYCLES - 1)
                                                : `COUNT_W'(`CONV_CYCLES - 1); // RQ2
                     conv_state_q[c] <= dac_ctrl_pkg::conv_busy;
                  end
               end
               dac_ctrl_pkg::conv_busy: begin
                  if (busy_cnt_q[c] == '0) begin
                     conv_state_q[c] <= dac_ctrl_pkg::conv_idle;
                  end else begin
                     busy_cnt_q[c] <= busy_cnt_q[c] - `COUNT_W'(1);
                  end
               end
               default: conv_state_q[c] <= dac_ctrl_pkg::conv_idle;
            endcase
         end
      end

      // Low power drops the core while idle; normal mode keeps it driving
      always_ff @(posedge clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            core_power_q[c] <= 1'b0;
         end else begin
            core_power_q[c] <= chan_on[c] && (!low_power || take[c] ||
                               conv_state_q[c] == dac_ctrl_pkg::conv_busy); // RQ1 RQ3
         end
      end
   end

   // ----------------------------------------
   // Read path and outputs
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            `OFS_MAIN_CONTROL: rdata_out <= main_control_q;
            `OFS_CHANNEL_TRIGGER_CONTROL: rdata_out <= channel_trigger_control_q;
            `OFS_REFERENCE_ALIGN_CONTROL: rdata_out <= reference_align_control_q;
            `OFS_EVENT_SOURCE_CONTROL: rdata_out <= event_source_control_q;
            `OFS_BUFFER_EMPTY_FLAGS: rdata_out <= {6'h00, empty_q}; // RQ11
            `OFS_CONVERTER_STATE: rdata_out <= {4'h0, updated_q,
                                                conv_state_q[1] == dac_ctrl_pkg::conv_busy,
                                                conv_state_q[0] == dac_ctrl_pkg::conv_busy};
            `OFS_CHAN0_SAMPLE_LOW: rdata_out <= sample_view(sample_q[0], left_align_select, 1'b0);
            `OFS_CHAN0_SAMPLE_HIGH: rdata_out <= sample_view(sample_q[0], left_align_select, 1'b1);
            `OFS_CHAN1_SAMPLE_LOW: rdata_out <= sample_view(sample_q[1], left_align_select, 1'b0);
            `OFS_CHAN1_SAMPLE_HIGH: rdata_out <= sample_view(sample_q[1], left_align_select, 1'b1);
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dma_req_out <= 2'b00;
         ch0_sample_out <= 12'h000;
         ch1_sample_out <= 12'h000;
         core_power_out <= 2'b00;
         ref_select_out <= 2'b00;
         pin_enable_out <= 2'b00;
         internal_route_out <= 1'b0;
      end else begin
         // Mirrors the flag one cycle later; DMA sees the flag, not a derived state
         dma_req_out <= empty_q; // RQ13
         ch0_sample_out <= out_sample_q[0];
         ch1_sample_out <= out_sample_q[1];
         core_power_out <= core_power_q;
         ref_select_out <= reference_align_control_q[4:3]; // RQ7
         pin_enable_out[0] <= main_control_q[`BIT_CH0_PIN_OUTPUT_ENABLE] &&
                              !main_control_q[`BIT_INTERNAL_ROUTE_ENABLE]; // RQ19
         pin_enable_out[1] <= main_control_q[`BIT_CH1_PIN_OUTPUT_ENABLE]; // RQ19
         internal_route_out <= main_control_q[`BIT_INTERNAL_ROUTE_ENABLE]; // RQ19
      end
   end

endmodule

`default_nettype wire

// *** dac_event_source.sv ***
// Event system stand-in: drives one event channel high for a few cycles on request.
// Assumes the same clock as the block; the block synchronises the lines itself.
`timescale 1ns/100ps
`default_nettype none
module dac_event_source (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Request from the bench
   input wire logic [2:0] ch_in,
   input wire logic fire_in,
   // Event channels
   output logic [7:0] event_out
);
   logic [2:0] left_q;
   logic [7:0] line_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         left_q <= 3'h0;
         line_q <= 8'h00;
      end else if (fire_in) begin
         left_q <= 3'h4;
         line_q <= 8'h01 << ch_in;
      end else if (left_q != 3'h0) begin
         left_q <= left_q - 3'h1;
      end
   end
   // Pulse spans several cycles so the two-flop synchroniser cannot miss it
   assign event_out = (left_q != 3'h0) ? line_q : 8'h00;
endmodule
`default_nettype wire

// *** dac_ctrl_chk_sva.sv ***
// Port assertions for the DAC control block.
// Assumes one clock domain and binding to the block's top module.
`timescale 1ns/100ps
`default_nettype none
module dac_ctrl_chk (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [5:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   // Core side
   input wire logic [1:0] dma_req_out,
   input wire logic [11:0] ch0_sample_out,
   input wire logic [11:0] ch1_sample_out,
   input wire logic [1:0] core_power_out,
   input wire logic [1:0] ref_select_out,
   input wire logic [1:0] pin_enable_out,
   input wire logic internal_route_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // Shadow of the global enable, seen from the write traffic
   logic en_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en_q <= 1'b0;
      end else if (wr_in && addr_in == 6'h00) begin
         en_q <= wdata_in[0];
      end
   end
   a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_unmapped_read: assert property (rd_in && addr_in == 6'h04 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_bits: assert property (rd_in && addr_in == 6'h01 |=> (rdata_out & 8'h9c) == 8'h00)
      else $error("reserved trigger control bits not zero");
   a_ref_follows: assert property (wr_in && addr_in == 6'h02 ##1 !(wr_in && addr_in == 6'h02)
      |=> ref_select_out == $past(wdata_in[4:3], 2))
      else $error("reference select does not follow write");
   a_pin_follows: assert property (wr_in && addr_in == 6'h00 ##1 !(wr_in && addr_in == 6'h00)
      |=> pin_enable_out == {$past(wdata_in[3], 2), $past(wdata_in[2], 2) & ~$past(wdata_in[4], 2)}
      && internal_route_out == $past(wdata_in[4], 2))
      else $error("pin enables do not follow write");
   a_route_blocks_pin: assert property (internal_route_out |-> !pin_enable_out[0])
      else $error("channel zero pin driven while routed inside");
   a_dma_on_commit: assert property (wr_in && addr_in == 6'h19 |-> ##[1:3] !dma_req_out[0])
      else $error("DMA request not dropped after commit");
   a_off_no_conv: assert property (!en_q [*3] |=> $stable(ch0_sample_out) && $stable(ch1_sample_out))
      else $error("conversion while disabled");
   a_off_no_power: assert property (!en_q [*3] |-> core_power_out == 2'b00)
      else $error("core powered while disabled");
endmodule
bind dual_channel_dac_control dac_ctrl_chk u_dac_ctrl_chk (.clk_in(clk_in), .nrst_in(nrst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .dma_req_out(dma_req_out), .ch0_sample_out(ch0_sample_out), .ch1_sample_out(ch1_sample_out),
   .core_power_out(core_power_out),
   .ref_select_out(ref_select_out), .pin_enable_out(pin_enable_out), .internal_route_out(internal_route_out));
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the DAC control block, driven through its register port.
// Assumes a normal-mode conversion keeps a channel busy about 100 cycles, a low-power one about 200.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_in;
   logic nrst_in;
   logic [5:0] addr_in;
   logic [7:0] wdata_in;
   logic wr_in;
   logic rd_in;
   logic [7:0] rdata_out;
   logic [7:0] event_in;
   logic [1:0] dma_req_out;
   logic [11:0] ch0_sample_out;
   logic [11:0] ch1_sample_out;
   logic [1:0] core_power_out;
   logic [1:0] ref_select_out;
   logic [1:0] pin_enable_out;
   logic internal_route_out;
   logic [2:0] ev_ch;
   logic fire;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   localparam logic [5:0] ra [4] = '{6'h01, 6'h02, 6'h03, 6'h05};
   localparam logic [7:0] rm [4] = '{8'h63, 8'h19, 8'h0f, 8'h00};
   dual_channel_dac_control u_dual_channel_dac_control (.clk_in(clk_in), .nrst_in(nrst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .event_in(event_in), .dma_req_out(dma_req_out), .ch0_sample_out(ch0_sample_out),
      .ch1_sample_out(ch1_sample_out), .core_power_out(core_power_out), .ref_select_out(ref_select_out),
      .pin_enable_out(pin_enable_out), .internal_route_out(internal_route_out));
   dac_event_source u_dac_event_source (.clk_in(clk_in), .nrst_in(nrst_in), .ch_in(ev_ch),
      .fire_in(fire), .event_out(event_in));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // ----------------------------------------
   // Access and check tasks
   // ----------------------------------------
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(12'(rdata_out), 12'(exp), "read data");
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic pulse(input logic [2:0] c);
      @(posedge clk_in);
      ev_ch <= c;
      fire <= 1'b1;
      @(posedge clk_in);
      fire <= 1'b0;
      wait_cyc(12);
   endtask
   // Hang guard: the sequence needs well under 4000 cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         final_report;
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst_in = 1'b0;
      addr_in = 6'h00;
      wdata_in = 8'h00;
      wr_in = 1'b0;
      rd_in = 1'b0;
      ev_ch = 3'h0;
      fire = 1'b0;
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      chk(12'(dma_req_out), 12'h000, "dma after reset");
      for (int i = 0; i < 4; i++) begin
         rd(ra[i], 8'h00);
         wr(ra[i], 8'hff);
         rd(ra[i], rm[i]);
      end
      wr(6'h04, 8'hff);
      rd(6'h04, 8'h00);
      for (int r = 0; r < 4; r++) begin
         wr(6'h02, 8'(r << 3));
         wait_cyc(2);
         chk(12'(ref_select_out), 12'(r), "reference select");
      end
      wr(6'h00, 8'h1d);
      wait_cyc(2);
      chk(12'({pin_enable_out, internal_route_out}), 12'h005, "pin routing");
      wr(6'h00, 8'h0c);
      wait_cyc(2);
      chk(12'({pin_enable_out, internal_route_out}), 12'h006, "pin routing");
      wr(6'h01, 8'h00);
      wr(6'h02, 8'h00);
      wr(6'h18, 8'h55);
      wr(6'h19, 8'h05);
      wr(6'h18, 8'h34);
      wr(6'h19, 8'h02);
      wait_cyc(110);
      chk(ch0_sample_out, 12'h000, "ch0 sample while off");
      wr(6'h00, 8'h01);
      wait_cyc(110);
      chk(ch0_sample_out, 12'h234, "ch0 sample");
      chk(12'(dma_req_out), 12'h001, "dma request");
      rd(6'h05, 8'h01);
      rd(6'h18, 8'h34);
      wr(6'h18, 8'hff);
      wr(6'h19, 8'hf7);
      wait_cyc(110);
      chk(ch0_sample_out, 12'h7ff, "ch0 sample");
      rd(6'h19, 8'h07);
      wr(6'h02, 8'h01);
      rd(6'h19, 8'h7f);
      rd(6'h18, 8'hf0);
      wr(6'h18, 8'ha7);
      wr(6'h19, 8'hbc);
      wait_cyc(110);
      chk(ch0_sample_out, 12'hbca, "ch0 left sample");
      rd(6'h18, 8'ha0);
      wr(6'h18, 8'h00);
      wr(6'h19, 8'h81);
      wait_cyc(110);
      chk(ch0_sample_out, 12'h810, "ch0 eight-bit sample");
      wr(6'h02, 8'h00);
      wr(6'h01, 8'h22);
      wr(6'h03, 8'h0b);
      wr(6'h1a, 8'h21);
      wr(6'h1b, 8'h03);
      pulse(3'h3);
      chk(ch1_sample_out, 12'h000, "ch1 before its event");
      pulse(3'h4);
      chk(ch1_sample_out, 12'h321, "ch1 event sample");
      rd(6'h05, 8'h03);
      wr(6'h01, 8'h41);
      for (int c = 0; c < 8; c++) begin
         wr(6'h03, 8'(c));
         wr(6'h18, 8'h00);
         wr(6'h19, 8'(8 + c));
         pulse(3'(c + 1));
         chk(ch0_sample_out, (c == 0) ? 12'h810 : 12'(12'h800 + ((c - 1) << 8)), "ch0 wrong event");
         pulse(3'(c));
         chk(ch0_sample_out, 12'(12'h800 + (c << 8)), "ch0 event sample");
         wait_cyc(100);
      end
      wr(6'h00, 8'h03);
      wait_cyc(2);
      chk(12'(core_power_out), 12'h000, "core power idle low power");
      wr(6'h1a, 8'h11);
      wr(6'h1b, 8'h01);
      wait_cyc(4);
      chk(12'(core_power_out), 12'h002, "core power busy low power");
      chk(ch1_sample_out, 12'h111, "ch1 auto sample");
      wr(6'h1a, 8'h22);
      wr(6'h1b, 8'h02);
      wait_cyc(150);
      chk(ch1_sample_out, 12'h111, "ch1 still busy low power");
      wait_cyc(60);
      chk(ch1_sample_out, 12'h222, "ch1 after double time");
      final_report;
   end
endmodule
`default_nettype wire
